// file: design/interrupt_flag_status_regs.sv
// Top: two interrupt flag status registers behind an APB slave
// Function
// [RULE_01] Flag reads 1 after its source requests, 0 while nothing is pending.
// [RULE_02] First register: serial2 transmit at bit 15, receive at bit 14.
// [RULE_03] First register: external line 2 at bit 13, line 1 at bit 4.
// [RULE_04] First register: timer five at bit 12, timer four at bit 11.
// [RULE_05] First register: compare out 4 at bit 10, out 3 at bit 9.
// [RULE_06] Transfer done: chan 2 first bit 8; chan 4 bit 14, chan 3 bit 4 second.
// [RULE_07] First register: capture in 8 at bit 7, capture in 7 at bit 6.
// [RULE_08] First register: pin change at bit 3, comparator at bit 2.
// [RULE_09] First register: two-wire master at bit 1, slave at bit 0.
// [RULE_10] Second register: parallel port at bit 13.
// [RULE_11] Second register: CAN event bit 3, rx ready bit 2; off without CAN.
// [RULE_12] Second register: serial periph2 event bit 1, error bit 0.
// [RULE_13] Unimplemented bits ignore writes and read 0.
// [RULE_14] Request sets flag regardless of enable; held until written 0; write 1 sets.
`timescale 1ns/10ps
module interrupt_flag_status_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic serial2_transmit_req,
  input wire logic serial2_receive_req,
  input wire logic ext_line2_req,
  input wire logic ext_line1_req,
  input wire logic timer_five_req,
  input wire logic timer_four_req,
  input wire logic compare_out4_req,
  input wire logic compare_out3_req,
  input wire logic xfer_chan2_done_req,
  input wire logic xfer_chan3_done_req,
  input wire logic xfer_chan4_done_req,
  input wire logic capture_in8_req,
  input wire logic capture_in7_req,
  input wire logic pin_change_req,
  input wire logic comparator_event_req,
  input wire logic twowire1_master_req,
  input wire logic twowire1_slave_req,
  input wire logic parallel_port_req,
  input wire logic can_event_req,
  input wire logic can_rx_ready_req,
  input wire logic serial_periph2_event_req,
  input wire logic serial_periph2_error_req,
  output logic [15:0] interrupt_flags_one,
  output logic [15:0] interrupt_flags_two,
  output logic irq
);

  logic [15:0] req_one;
  logic [15:0] req_two;
  logic [15:0] allow_two;
  logic [15:0] flags_one;
  logic [15:0] flags_two;
  logic raised_one;
  logic raised_two;
  logic wr_pulse;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_value;
  logic rd_hit;
  logic can_present;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic bad_access;

  // ----------------------------------------------------------------
  // Source placement
  // ----------------------------------------------------------------
  always_comb begin
    req_one = 16'h0000;
    req_one[ifs_pkg::BIT_SERIAL2_TRANSMIT] = serial2_transmit_req;  // see [RULE_02]
    req_one[ifs_pkg::BIT_SERIAL2_RECEIVE] = serial2_receive_req;  // see [RULE_02]
    req_one[ifs_pkg::BIT_EXT_LINE2] = ext_line2_req;  // see [RULE_03]
    req_one[ifs_pkg::BIT_EXT_LINE1] = ext_line1_req;  // see [RULE_03]
    req_one[ifs_pkg::BIT_TIMER_FIVE] = timer_five_req;  // see [RULE_04]
    req_one[ifs_pkg::BIT_TIMER_FOUR] = timer_four_req;  // see [RULE_04]
    req_one[ifs_pkg::BIT_COMPARE_OUT4] = compare_out4_req;  // see [RULE_05]
    req_one[ifs_pkg::BIT_COMPARE_OUT3] = compare_out3_req;  // see [RULE_05]
    req_one[ifs_pkg::BIT_XFER_CHAN2] = xfer_chan2_done_req;  // see [RULE_06]
    req_one[ifs_pkg::BIT_CAPTURE_IN8] = capture_in8_req;  // see [RULE_07]
    req_one[ifs_pkg::BIT_CAPTURE_IN7] = capture_in7_req;  // see [RULE_07]
    req_one[ifs_pkg::BIT_PIN_CHANGE] = pin_change_req;  // see [RULE_08]
    req_one[ifs_pkg::BIT_COMPARATOR] = comparator_event_req;  // see [RULE_08]
    req_one[ifs_pkg::BIT_TWOWIRE1_MASTER] = twowire1_master_req;  // see [RULE_09]
    req_one[ifs_pkg::BIT_TWOWIRE1_SLAVE] = twowire1_slave_req;  // see [RULE_09]
  end

  always_comb begin
    req_two = 16'h0000;
    req_two[ifs_pkg::BIT_XFER_CHAN4] = xfer_chan4_done_req;  // see [RULE_06]
    req_two[ifs_pkg::BIT_XFER_CHAN3] = xfer_chan3_done_req;  // see [RULE_06]
    req_two[ifs_pkg::BIT_PARALLEL_PORT] = parallel_port_req;  // see [RULE_10]
    req_two[ifs_pkg::BIT_CAN_EVENT] = can_event_req;  // see [RULE_11]
    req_two[ifs_pkg::BIT_CAN_RX_READY] = can_rx_ready_req;  // see [RULE_11]
    req_two[ifs_pkg::BIT_SERIAL_PERIPH2_EVENT] = serial_periph2_event_req;  // see [RULE_12]
    req_two[ifs_pkg::BIT_SERIAL_PERIPH2_ERROR] = serial_periph2_error_req;  // see [RULE_12]
  end

  // Without a CAN controller its requests never reach the flags
  assign allow_two = can_present ? 16'hFFFF : ~ifs_pkg::CAN_BITS;  // see [RULE_11]

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  flag_bank #(
    .IMPL(ifs_pkg::IMPL_ONE)
  ) u_bank_one (
    .pclk(pclk),
    .presetn(presetn),
    .req(req_one),
    .allow(16'hFFFF),
    .wr_en(wr_pulse && wr_addr == ifs_pkg::OFS_FLAGS_ONE),
    .wr_data(wr_data[15:0]),
    .flags(flags_one),
    .raised(raised_one)
  );

  flag_bank #(
    .IMPL(ifs_pkg::IMPL_TWO)
  ) u_bank_two (
    .pclk(pclk),
    .presetn(presetn),
    .req(req_two),
    .allow(allow_two),
    .wr_en(wr_pulse && wr_addr == ifs_pkg::OFS_FLAGS_TWO),
    .wr_data(wr_data[15:0] & (can_present ? 16'hFFFF : ~ifs_pkg::CAN_BITS)),
    .flags(flags_two),
    .raised(raised_two)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_value = 32'h00000000;
    case (paddr)
      ifs_pkg::OFS_FLAGS_ONE: rd_value = {16'h0000, flags_one};
      ifs_pkg::OFS_FLAGS_TWO: rd_value = {16'h0000, flags_two};
      ifs_pkg::OFS_IRQ_STATUS: rd_value = {30'h0, irq_status};
      ifs_pkg::OFS_IRQ_MASK: rd_value = {30'h0, irq_mask};
      ifs_pkg::OFS_CAN_PRESENT: rd_value = {31'h0, can_present};
      default: rd_hit = 1'b0;
    endcase
  end

  apb_regs u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rd_value(rd_value),
    .rd_hit(rd_hit),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  assign bad_access = psel && penable && !pready && !rd_hit;

  // ----------------------------------------------------------------
  // Configuration and block interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_present <= ifs_pkg::RST_CAN_PRESENT;
    end else if (wr_pulse && wr_addr == ifs_pkg::OFS_CAN_PRESENT) begin
      can_present <= wr_data[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= ifs_pkg::RST_IRQ;
    end else if (wr_pulse && wr_addr == ifs_pkg::OFS_IRQ_MASK) begin
      irq_mask <= wr_data[1:0];
    end
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= ifs_pkg::RST_IRQ;
    end else begin
      if (wr_pulse && wr_addr == ifs_pkg::OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wr_data[1:0]) |
                      {raised_one || raised_two, bad_access};
      end else begin
        irq_status <= irq_status | {raised_one || raised_two, bad_access};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      interrupt_flags_one <= ifs_pkg::RST_FLAGS;
      interrupt_flags_two <= ifs_pkg::RST_FLAGS;
    end else begin
      irq <= |(irq_status & irq_mask);
      interrupt_flags_one <= flags_one;
      interrupt_flags_two <= flags_two;
    end
  end

endmodule

// file: design/ifs_pkg.sv
// Package: register map, field positions and reset values of the flag status block
package ifs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_FLAGS_ONE = 12'h000;
  localparam logic [11:0] OFS_FLAGS_TWO = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFS_CAN_PRESENT = 12'h010;

  // ----------------------------------------------------------------
  // Field positions, first flag register
  // ----------------------------------------------------------------
  localparam int BIT_SERIAL2_TRANSMIT = 15;
  localparam int BIT_SERIAL2_RECEIVE = 14;
  localparam int BIT_EXT_LINE2 = 13;
  localparam int BIT_TIMER_FIVE = 12;
  localparam int BIT_TIMER_FOUR = 11;
  localparam int BIT_COMPARE_OUT4 = 10;
  localparam int BIT_COMPARE_OUT3 = 9;
  localparam int BIT_XFER_CHAN2 = 8;
  localparam int BIT_CAPTURE_IN8 = 7;
  localparam int BIT_CAPTURE_IN7 = 6;
  localparam int BIT_EXT_LINE1 = 4;
  localparam int BIT_PIN_CHANGE = 3;
  localparam int BIT_COMPARATOR = 2;
  localparam int BIT_TWOWIRE1_MASTER = 1;
  localparam int BIT_TWOWIRE1_SLAVE = 0;

  // ----------------------------------------------------------------
  // Field positions, second flag register
  // ----------------------------------------------------------------
  localparam int BIT_XFER_CHAN4 = 14;
  localparam int BIT_PARALLEL_PORT = 13;
  localparam int BIT_XFER_CHAN3 = 4;
  localparam int BIT_CAN_EVENT = 3;
  localparam int BIT_CAN_RX_READY = 2;
  localparam int BIT_SERIAL_PERIPH2_EVENT = 1;
  localparam int BIT_SERIAL_PERIPH2_ERROR = 0;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL_ONE = 16'hFFDF;
  localparam logic [15:0] IMPL_TWO = 16'h601F;
  localparam logic [15:0] CAN_BITS = 16'h000C;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic RST_CAN_PRESENT = 1'b1;

  // Interrupt status bit positions
  localparam int IRQ_BAD_ADDR = 0;
  localparam int IRQ_FLAG_RAISED = 1;

endpackage

// file: design/flag_bank.sv
// Flag bank: one sticky flag register of sixteen positions
`timescale 1ns/10ps
module flag_bank #(
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] req,
  input wire logic [15:0] allow,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] flags,
  output logic raised
);

  logic [15:0] next_flags;

  // ----------------------------------------------------------------
  // Per-bit flag update
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      if (IMPL[i]) begin : g_impl
        always_comb begin
          next_flags[i] = flags[i];
          if (wr_en) begin
            next_flags[i] = wr_data[i];  // see [RULE_14]
          end
          // Request wins over a software clear in the same cycle
          if (req[i] && allow[i]) begin
            next_flags[i] = 1'b1;  // see [RULE_01] see [RULE_14]
          end
        end
      end else begin : g_unimpl
        always_comb begin
          next_flags[i] = 1'b0;  // see [RULE_13]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= ifs_pkg::RST_FLAGS;
    end else begin
      flags <= next_flags & IMPL;  // see [RULE_13]
    end
  end

  // One-cycle pulse when any flag rises from a source request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raised <= 1'b0;
    end else begin
      raised <= |(req & allow & IMPL & ~flags);
    end
  end

endmodule

// file: design/apb_regs.sv
// APB slave front end: decodes one access per transfer and returns one-wait read data
`timescale 1ns/10ps
module apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] rd_value,
  input wire logic rd_hit,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_pulse,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data
);

  logic access;

  assign access = psel && penable && !pready;

  // ----------------------------------------------------------------
  // Answer: pready one cycle into the access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && !rd_hit;
      if (access && !pwrite && rd_hit) begin
        prdata <= rd_value;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Write strobe is the completing edge of the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pulse <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
    end else begin
      wr_pulse <= access && pwrite && rd_hit;
      wr_addr <= paddr;
      wr_data <= pwdata;
    end
  end

endmodule

// file: verif/interrupt_flag_status_regs_assertions.sv
// Checker: port-level properties of the flag status block
`timescale 1ns/10ps
module interrupt_flag_status_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic serial2_transmit_req,
  input wire logic parallel_port_req,
  input wire logic [15:0] interrupt_flags_one,
  input wire logic [15:0] interrupt_flags_two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence tx_seen;
    ##2 interrupt_flags_one[15];
  endsequence
  // Port copy lags a clearing write by one edge after the bus lets go
  sequence flag_held;
    interrupt_flags_one[15] && !(psel && pwrite) && !$past(psel && pwrite);
  endsequence
  sequence unimpl_zero;
    !interrupt_flags_one[5] && !(|(interrupt_flags_two & 16'h9FE0));
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_READY_WAIT: assert property (access_wait |=> pready)
    else $error("pready missing after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  AST_TX_SET: assert property (serial2_transmit_req |-> tx_seen)
    else $error("transmit flag not set by request");
  AST_PORT_SET: assert property (parallel_port_req |-> ##2 interrupt_flags_two[13])
    else $error("parallel port flag not set by request");
  AST_UNIMPL: assert property (unimpl_zero)
    else $error("unimplemented flag bit set");
  AST_FLAG_HOLD: assert property (flag_held |=> interrupt_flags_one[15])
    else $error("flag dropped without a write");
endmodule

bind interrupt_flag_status_regs interrupt_flag_status_regs_checker chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .prdata, .pslverr,
  .serial2_transmit_req, .parallel_port_req, .interrupt_flags_one, .interrupt_flags_two
);

// file: verif/req_sources.sv
// Peripheral request sources: each commanded bit raises its line one cycle later, for as long as it stays commanded
`timescale 1ns/10ps
module req_sources (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] fire_one,
  input wire logic [15:0] fire_two,
  output logic [15:0] r1,
  output logic [15:0] r2
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r1 <= 16'h0000;
      r2 <= 16'h0000;
    end else begin
      r1 <= fire_one;
      r2 <= fire_two;
    end
  end
endmodule

// file: verif/test_interrupt_flag_status_regs.sv
// Testbench: register map, sticky flags and interrupt of the flag status block
`timescale 1ns/10ps
module test_interrupt_flag_status_regs;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [15:0] fire_one = 16'h0000;
  logic [15:0] fire_two = 16'h0000;
  logic [15:0] r1;
  logic [15:0] r2;
  logic [15:0] interrupt_flags_one;
  logic [15:0] interrupt_flags_two;
  logic irq;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int n_tests = 0;

  always #20 pclk = ~pclk;

  req_sources src (.pclk, .presetn, .fire_one, .fire_two, .r1, .r2);

  interrupt_flag_status_regs uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .serial2_transmit_req(r1[15]), .serial2_receive_req(r1[14]),
    .ext_line2_req(r1[13]), .ext_line1_req(r1[4]),
    .timer_five_req(r1[12]), .timer_four_req(r1[11]),
    .compare_out4_req(r1[10]), .compare_out3_req(r1[9]),
    .xfer_chan2_done_req(r1[8]), .xfer_chan3_done_req(r2[4]), .xfer_chan4_done_req(r2[14]),
    .capture_in8_req(r1[7]), .capture_in7_req(r1[6]),
    .pin_change_req(r1[3]), .comparator_event_req(r1[2]),
    .twowire1_master_req(r1[1]), .twowire1_slave_req(r1[0]),
    .parallel_port_req(r2[13]), .can_event_req(r2[3]), .can_rx_ready_req(r2[2]),
    .serial_periph2_event_req(r2[1]), .serial_periph2_error_req(r2[0]),
    .interrupt_flags_one, .interrupt_flags_two, .irq
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask

  task automatic fire(input logic [15:0] a, input logic [15:0] b);
    @(posedge pclk);
    fire_one <= a;
    fire_two <= b;
    @(posedge pclk);
    fire_one <= 16'h0000;
    fire_two <= 16'h0000;
    repeat (3) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(ifs_pkg::OFS_FLAGS_ONE, 32'h0, "flags one");
    rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h0, "flags two");
    rdchk(ifs_pkg::OFS_IRQ_STATUS, 32'h0, "irq status");
    rdchk(ifs_pkg::OFS_IRQ_MASK, 32'h0, "irq mask");
    rdchk(ifs_pkg::OFS_CAN_PRESENT, 32'h1, "can present");
  endtask

  task automatic t_map();
    for (int k = 0; k < 16; k++) begin
      if (k != 5) begin
        fire(16'h1 << k, 16'h0000);
        rdchk(ifs_pkg::OFS_FLAGS_ONE, 32'h1 << k, "flags one");
        check("one port", 32'h1 << k, 32'(interrupt_flags_one));
        wr(ifs_pkg::OFS_FLAGS_ONE, 32'h0);
      end
      if ((16'h601F >> k) & 16'h1) begin
        fire(16'h0000, 16'h1 << k);
        rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h1 << k, "flags two");
        check("two port", 32'h1 << k, 32'(interrupt_flags_two));
        wr(ifs_pkg::OFS_FLAGS_TWO, 32'h0);
        rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h0, "two cleared");
      end
    end
  endtask

  task automatic t_sw();
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'hFFFFFFFF);
    wr(ifs_pkg::OFS_FLAGS_TWO, 32'hFFFFFFFF);
    rdchk(ifs_pkg::OFS_FLAGS_ONE, 32'hFFDF, "one all set");
    rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h601F, "two all set");
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'h0);
    fire(16'h8000, 16'h0000);
    repeat (8) @(posedge pclk);
    rdchk(ifs_pkg::OFS_FLAGS_ONE, 32'h8000, "flag held");
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'h0);
    wr(ifs_pkg::OFS_FLAGS_TWO, 32'h0);
  endtask

  // Request meets the completing edge of a clearing write
  task automatic t_race();
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'h3);
    fork
      wr(ifs_pkg::OFS_FLAGS_ONE, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        fire_one <= 16'h0002;
        @(posedge pclk);
        fire_one <= 16'h0000;
      end
    join
    rdchk(ifs_pkg::OFS_FLAGS_ONE, 32'h2, "set beats clear");
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'h0);
  endtask

  task automatic t_can();
    wr(ifs_pkg::OFS_CAN_PRESENT, 32'h0);
    fire(16'h0000, 16'h000C);
    rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h0, "no can request");
    wr(ifs_pkg::OFS_FLAGS_TWO, 32'hFFFF);
    rdchk(ifs_pkg::OFS_FLAGS_TWO, 32'h6013, "no can write");
    wr(ifs_pkg::OFS_FLAGS_TWO, 32'h0);
    wr(ifs_pkg::OFS_CAN_PRESENT, 32'h1);
  endtask

  task automatic t_irq();
    wr(ifs_pkg::OFS_IRQ_STATUS, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    check("bad addr err", 32'h1, 32'(er));
    check("bad addr data", 32'h0, rd);
    rdchk(ifs_pkg::OFS_IRQ_STATUS, 32'h1, "irq status");
    check("irq masked", 32'h0, 32'(irq));
    wr(ifs_pkg::OFS_IRQ_MASK, 32'h3);
    repeat (3) @(posedge pclk);
    check("irq set", 32'h1, 32'(irq));
    wr(ifs_pkg::OFS_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge pclk);
    check("irq clear", 32'h0, 32'(irq));
    fire(16'h0001, 16'h0000);
    @(posedge pclk);
    check("irq flag", 32'h1, 32'(irq));
    rdchk(ifs_pkg::OFS_IRQ_STATUS, 32'h2, "irq status");
    wr(ifs_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    check("irq off", 32'h0, 32'(irq));
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_map();
    t_sw();
    t_race();
    t_can();
    t_irq();
    wr(ifs_pkg::OFS_FLAGS_ONE, 32'hFFFF);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    end_of_test();
  end
endmodule
